// File: ovt_ctl.sv
`timescale 1ns/1ps
// Overview of operation
// - Output above target plus margin: high gate low, low gate high.
// - After a trip the target ramps down stepwise to zero.
// - During ramp, low gate follows output versus falling target plus margin.
// - Target at zero after trip: high gate low, low gate high until enable goes low.
// - Trip latch clears only when enable is taken low.
// - During soft-start the trip threshold is a fixed 2.9 V.
// - Temperature sensing and alerting act only in normal mode.
// - Sensed voltage is converted to temperature and readable at 17h.
// - Sense voltage past internal thresholds asserts alert or hot outputs.
module ovt_ctl
   import ovt_pkg::*;
#(
   parameter logic [11:0] OV_MARGIN_MV = 12'h190,
   parameter logic [9:0]  ALERT_CODE   = 10'h180,
   parameter logic [9:0]  HOT_CODE     = 10'h140
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        enable,
   input  wire logic        soft_start,
   input  wire logic        normal_mode,
   input  wire logic        pwm_in,
   input  wire logic [11:0] output_sense_mv,
   input  wire logic [11:0] vid_target_mv,
   input  wire logic [9:0]  temperature_sense_input_code,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   output logic             high_side_gate_drive,
   output logic             low_side_gate_drive,
   output logic             overvoltage_trip,
   output logic             alert_out_n,
   output logic             regulator_hot_n
);

   ovt_conv_if cv ();

   ovt_state_t  st_ff;
   ovt_state_t  nxt_st;
   logic [11:0] tgt_ff;
   logic [11:0] nxt_tgt;
   logic [11:0] ramp_cnt_ff;
   logic [11:0] smp_cnt_ff;
   logic        hs_ff;
   logic        ls_ff;
   logic        nxt_hs;
   logic        nxt_ls;
   logic        trip_ff;
   logic        req_ff;
   logic [9:0]  code_ff;
   logic [7:0]  temp_ff;
   logic [7:0]  rdata_ff;
   logic        rvalid_ff;
   logic        alert_n_ff;
   logic        hot_n_ff;

   // Decode and compare
   wire  [12:0] rel_thr_w  = {1'b0, tgt_ff} + {1'b0, OV_MARGIN_MV};
   wire  [12:0] run_thr_w  = soft_start ? {1'b0, OVT_SS_OV_MV}
                                        : rel_thr_w;
   wire         run_ov_w   = {1'b0, output_sense_mv} > run_thr_w;
   wire         ramp_ov_w  = {1'b0, output_sense_mv} > rel_thr_w;
   wire         trip_w     = (st_ff == OVT_ST_RUN) && run_ov_w;
   wire         ramp_tick_w = ramp_cnt_ff == OVT_RAMP_CYC - 12'h001;
   wire         smp_tick_w  = smp_cnt_ff == OVT_TEMP_CYC - 12'h001;
   wire         addr_hit_w  = reg_addr == OVT_REG_TEMP;
   wire         alert_w     = normal_mode && (temperature_sense_input_code < ALERT_CODE);
   wire         hot_w       = normal_mode && (temperature_sense_input_code < HOT_CODE);

   always_comb begin
      nxt_st = st_ff;
      nxt_tgt = tgt_ff;
      nxt_hs = 1'b0;
      nxt_ls = 1'b0;
      if (!enable) begin
         nxt_st = OVT_ST_OFF;
         nxt_tgt = vid_target_mv;
      end else begin
         unique case (st_ff)
            OVT_ST_OFF: begin
               nxt_st = OVT_ST_RUN;
               nxt_tgt = vid_target_mv;
            end
            OVT_ST_RUN: begin
               nxt_tgt = vid_target_mv;
               nxt_hs = pwm_in;
               nxt_ls = !pwm_in;
               if (trip_w) begin
                  nxt_st = OVT_ST_RAMP;
                  nxt_hs = 1'b0;
                  nxt_ls = 1'b1;
               end
            end
            OVT_ST_RAMP: begin
               nxt_ls = ramp_ov_w;
               if (tgt_ff == 12'h000) begin
                  nxt_st = OVT_ST_HOLD;
                  nxt_ls = 1'b1;
               end else if (ramp_tick_w) begin
                  nxt_tgt = tgt_ff - OVT_RAMP_STEP_MV;
               end
            end
            OVT_ST_HOLD: begin
               nxt_ls = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff   <= OVT_ST_OFF;
         tgt_ff  <= OVT_CNT_RST;
         hs_ff   <= 1'b0;
         ls_ff   <= 1'b0;
         trip_ff <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         tgt_ff  <= nxt_tgt;
         hs_ff   <= nxt_hs;
         ls_ff   <= nxt_ls;
         trip_ff <= (nxt_st == OVT_ST_RAMP) || (nxt_st == OVT_ST_HOLD);
      end
   end

   // Ramp pacing restarts on each trip so the first step is a full period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramp_cnt_ff <= OVT_CNT_RST;
      end else if (st_ff != OVT_ST_RAMP || ramp_tick_w) begin
         ramp_cnt_ff <= OVT_CNT_RST;
      end else begin
         ramp_cnt_ff <= ramp_cnt_ff + 12'h001;
      end
   end

   // Periodic sampling of the sense code
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp_cnt_ff <= OVT_CNT_RST;
         req_ff     <= 1'b0;
         code_ff    <= 10'h000;
      end else begin
         smp_cnt_ff <= smp_tick_w ? OVT_CNT_RST
                                  : smp_cnt_ff + 12'h001;
         req_ff     <= smp_tick_w && normal_mode;
         if (smp_tick_w) begin
            code_ff <= temperature_sense_input_code;
         end
      end
   end

   assign cv.req  = req_ff;
   assign cv.code = code_ff;

   ovt_temp_conv u_conv (
      .clk (clk),
      .rst (rst),
      .cv  (cv.conv)
   );

   // Reading register and alert outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_ff    <= OVT_TEMP_RST;
         rdata_ff   <= OVT_RDATA_RST;
         rvalid_ff  <= 1'b0;
         alert_n_ff <= 1'b1;
         hot_n_ff   <= 1'b1;
      end else begin
         if (cv.ack) begin
            temp_ff <= cv.temp;
         end
         rvalid_ff  <= reg_rd;
         if (reg_rd) begin
            rdata_ff <= addr_hit_w ? temp_ff : OVT_RDATA_RST;
         end
         alert_n_ff <= !alert_w;
         hot_n_ff   <= !hot_w;
      end
   end

   assign high_side_gate_drive = hs_ff;
   assign low_side_gate_drive  = ls_ff;
   assign overvoltage_trip     = trip_ff;
   assign reg_rdata            = rdata_ff;
   assign reg_rvalid           = rvalid_ff;
   assign alert_out_n          = alert_n_ff;
   assign regulator_hot_n      = hot_n_ff;

   // Checks
   ov_force_gate_a: assert property (@(posedge clk) disable iff (rst)
      (enable && trip_w) |=> (!high_side_gate_drive && low_side_gate_drive))
      else $error("gates not forced on over-voltage");

   ramp_step_a: assert property (@(posedge clk) disable iff (rst)
      (enable && st_ff == OVT_ST_RAMP && ramp_tick_w && tgt_ff != 12'h000)
      |=> (tgt_ff == $past(tgt_ff) - 12'h001))
      else $error("target ramp step wrong");

   ramp_track_a: assert property (@(posedge clk) disable iff (rst)
      (enable && st_ff == OVT_ST_RAMP && tgt_ff != 12'h000)
      |=> (low_side_gate_drive == $past(ramp_ov_w) && !high_side_gate_drive))
      else $error("low gate not tracking during ramp");

   hold_gates_a: assert property (@(posedge clk) disable iff (rst)
      (st_ff == OVT_ST_HOLD && enable) |=> ((st_ff == OVT_ST_HOLD)
      && !high_side_gate_drive && low_side_gate_drive))
      else $error("hold state lost gate levels");

   trip_latch_a: assert property (@(posedge clk) disable iff (rst)
      (overvoltage_trip && enable) |=> overvoltage_trip)
      else $error("trip cleared without enable cycle");

   ss_thresh_a: assert property (@(posedge clk) disable iff (rst)
      (enable && st_ff == OVT_ST_RUN && soft_start
       && output_sense_mv <= OVT_SS_OV_MV) |=> !overvoltage_trip)
      else $error("false trip during soft-start");

   temp_mode_a: assert property (@(posedge clk) disable iff (rst)
      !normal_mode |=> (alert_out_n && regulator_hot_n && !cv.req))
      else $error("thermal activity outside normal mode");

   reg_read_a: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && addr_hit_w) |=> (reg_rvalid && reg_rdata == $past(temp_ff)))
      else $error("temperature register read wrong");

   hot_flag_a: assert property (@(posedge clk) disable iff (rst)
      (normal_mode && temperature_sense_input_code < HOT_CODE)
      |=> (!regulator_hot_n && !alert_out_n))
      else $error("hot threshold not flagged");

   refresh_a: assert property (@(posedge clk) disable iff (rst)
      (smp_tick_w && normal_mode) |=> cv.req ##1 cv.ack ##1
      (temp_ff == ovt_code_to_temp($past(code_ff, 2))))
      else $error("temperature refresh broken");

endmodule

// File: ovt_pkg.sv
package ovt_pkg;

   // Serial-bus register map
   localparam logic [7:0]  OVT_REG_TEMP     = 8'h17;
   localparam logic [7:0]  OVT_TEMP_RST     = 8'h00;
   localparam logic [7:0]  OVT_RDATA_RST    = 8'h00;

   // Fixed over-voltage threshold while soft-start runs: 2.9 V in mV
   localparam logic [11:0] OVT_SS_OV_MV     = 12'hB54;

   // Clock period
   localparam int          OVT_CLK_NS       = 40;

   // Target ramp: one millivolt per step after a trip
   localparam int          OVT_RAMP_STEP_NS = 1000;
   localparam int          OVT_RAMP_CYC_I   =
      (OVT_RAMP_STEP_NS + OVT_CLK_NS - 1) / OVT_CLK_NS;
   localparam logic [11:0] OVT_RAMP_CYC     = OVT_RAMP_CYC_I[11:0];
   localparam logic [11:0] OVT_RAMP_STEP_MV = 12'h001;

   // Temperature refresh interval
   localparam int          OVT_TEMP_PER_US  = 100;
   localparam int          OVT_TEMP_CYC_I   =
      (OVT_TEMP_PER_US * 1000) / OVT_CLK_NS;
   localparam logic [11:0] OVT_TEMP_CYC     = OVT_TEMP_CYC_I[11:0];
   localparam logic [11:0] OVT_CNT_RST      = 12'h000;

   localparam logic [9:0]  OVT_CODE_FULL    = 10'h3FF;

   typedef enum logic [1:0] {
      OVT_ST_OFF,
      OVT_ST_RUN,
      OVT_ST_RAMP,
      OVT_ST_HOLD
   } ovt_state_t;

   // NTC voltage falls as it warms, so a low code is a high temperature
   function automatic logic [7:0] ovt_code_to_temp(input logic [9:0] code);
      logic [9:0] diff;
      diff = OVT_CODE_FULL - code;
      return diff[9:2];
   endfunction

endpackage

// File: ovt_conv_if.sv
`timescale 1ns/1ps
interface ovt_conv_if;
   logic       req;
   logic [9:0] code;
   logic       ack;
   logic [7:0] temp;
   modport host (output req, output code, input ack, input temp);
   modport conv (input req, input code, output ack, output temp);
endinterface

// File: ovt_temp_conv.sv
`timescale 1ns/1ps
module ovt_temp_conv
   import ovt_pkg::*;
(
   input wire logic  clk,
   input wire logic  rst,
   ovt_conv_if.conv  cv
);

   logic       ack_ff;
   logic [7:0] temp_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_ff  <= 1'b0;
         temp_ff <= OVT_TEMP_RST;
      end else begin
         ack_ff  <= cv.req;
         if (cv.req) begin
            temp_ff <= ovt_code_to_temp(cv.code);
         end
      end
   end

   assign cv.ack  = ack_ff;
   assign cv.temp = temp_ff;

endmodule

// File: ovt_host_model.sv
`timescale 1ns/1ps
module ovt_host_model
(
   input  wire logic       clk,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_rd = 1'b0;
      reg_addr = 8'h00;
   end
   // Caller enters just after a rising edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 0;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      // Released address must not look like the last one
      reg_addr = ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) ok = 1;
         else begin
            @(posedge clk);
            #1;
         end
      end
      d = reg_rdata;
      // Idle edge so a following call never re-raises the strobe at once
      @(posedge clk);
      #1;
   endtask
endmodule

// File: tb_overvoltage_and_thermal_alert_ctl.sv
`timescale 1ns/1ps
module tb_overvoltage_and_thermal_alert_ctl;
   localparam logic [9:0] ALRT = 10'h180;
   localparam logic [9:0] HOT  = 10'h140;
   logic        clk = 0, rst = 1, enable = 0, soft_start = 0;
   logic        normal_mode = 0, pwm_in = 0, reg_rd, reg_rvalid;
   logic        hs, ls, trip, alert_n, hot_n;
   logic [11:0] sense = 0, vid = 20;
   logic [9:0]  code = 10'h3FF;
   logic [7:0]  reg_addr, reg_rdata, d;
   bit          ok;
   int          errors = 0, checked = 0, n, q[$];
   always #20 clk = ~clk;
   ovt_ctl #(.OV_MARGIN_MV(12'h190), .ALERT_CODE(ALRT), .HOT_CODE(HOT)) uut (
      .clk(clk), .rst(rst), .enable(enable), .soft_start(soft_start),
      .normal_mode(normal_mode), .pwm_in(pwm_in), .output_sense_mv(sense),
      .vid_target_mv(vid), .temperature_sense_input_code(code), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .high_side_gate_drive(hs), .low_side_gate_drive(ls),
      .overvoltage_trip(trip), .alert_out_n(alert_n),
      .regulator_hot_n(hot_n));
   ovt_host_model host (.clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   task automatic chk(string s, logic [11:0] e, logic [11:0] g);
      checked++;
      if (e !== g) begin
         errors++;
         $display("BAD %s exp %0h got %0h", s, e, g);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic rdchk(logic [7:0] a, logic [7:0] e);
      host.rd(a, d, ok);
      chk("rvalid", 1, ok);
      chk("rdata", e, d);
   endtask
   task automatic finish_test;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #4000000;
      errors++;
      finish_test;
   end
   initial begin
      void'($urandom(32'h3D61));
      cyc(10);
      chk("rst_gates", 0, {hs, ls, trip});
      chk("rst_alerts", 3, {alert_n, hot_n});
      rst = 0;
      rdchk(8'h17, 8'h00);
      enable = 1;
      sense = 420;
      cyc(3);
      repeat (8) begin
         pwm_in = 1'($urandom);
         cyc(1);
         chk("hs_run", pwm_in, hs);
         chk("ls_run", !pwm_in, ls);
         chk("trip_edge", 0, trip);
      end
      sense = 421;
      cyc(1);
      chk("trip_gates", 3'b011, {hs, ls, trip});
      sense = 410;
      cyc(2);
      chk("ls_ramp_lo", 0, ls);
      n = 3;
      while (ls !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      chk("ramp_time", 1, 12'(n > 248 && n < 304));
      sense = 300;
      cyc(2);
      chk("ls_toggle", 0, ls);
      sense = 0;
      cyc(300);
      chk("hold", 3'b011, {hs, ls, trip});
      enable = 0;
      cyc(2);
      chk("en_off", 0, {hs, ls, trip});
      enable = 1;
      vid = 1000;
      cyc(3);
      chk("restart", 0, trip);
      soft_start = 1;
      sense = 2900;
      cyc(3);
      chk("ss_hold", 0, trip);
      sense = 2901;
      cyc(2);
      chk("ss_trip", 1, trip);
      q = '{200 + $urandom % 800, 10'h180, 10'h17F, 10'h140, 10'h13F};
      normal_mode = 1;
      foreach (q[i]) begin
         code = 10'(q[i]);
         cyc(2600);
         chk("alert", q[i] >= ALRT, alert_n);
         chk("hot", q[i] >= HOT, hot_n);
         rdchk(8'h17, 8'((1023 - q[i]) / 4));
      end
      normal_mode = 0;
      // Hot code, so only the mode gate can keep the alerts quiet
      code = 10'h100;
      cyc(2600);
      chk("alerts_off", 3, {alert_n, hot_n});
      rdchk(8'h17, 8'((1023 - q[4]) / 4));
      rdchk(8'h18, 8'h00);
      finish_test;
   end
endmodule
